/* File: common/dcg_consts.svh */
// Purpose: offsets, field positions, reset values and counts of the
//          deviation clear and electronic gear block
// Assumes: byte addresses on an 8-bit AXI4-Lite address
// Notes:   definitions only
`ifndef DCG_CONSTS_SVH
`define DCG_CONSTS_SVH

// =====================================================================
// register byte offsets
`define DCG_OFF_CLR_MODE   8'h00
`define DCG_OFF_GEAR_WIDTH 8'h04
`define DCG_OFF_SHORT_NUM  8'h08
`define DCG_OFF_SHORT_DEN  8'h0C
`define DCG_OFF_LNUM_HI    8'h10
`define DCG_OFF_LNUM_LO    8'h14
`define DCG_OFF_LDEN_HI    8'h18
`define DCG_OFF_LDEN_LO    8'h1C
`define DCG_OFF_DEVIATION  8'h20
`define DCG_OFF_STATUS     8'h24

// =====================================================================
// field positions and encodings
`define DCG_CLR_MODE_LSB   4
`define DCG_CLR_MODE_MSB   7
`define DCG_GEAR_LONG_BIT  2
`define DCG_MODE_SERVO_OFF 4'h0
`define DCG_MODE_NEVER     4'h1
`define DCG_MODE_BOTH      4'h2

// =====================================================================
// reset values, scale and counts
`define DCG_RST_CLR_MODE   16'h0000
`define DCG_RST_GEAR_WIDTH 16'h0000
`define DCG_RST_SHORT_NUM  16'h0001
`define DCG_RST_SHORT_DEN  16'h0001
`define DCG_RST_LONG_HI    16'h0000
`define DCG_RST_LONG_LO    16'h0001
`define DCG_LONG_SCALE     16'h2710
`define DCG_DIV_STEPS      6'h20
`define DCG_RESP_OKAY      2'h0
`define DCG_RESP_SLVERR    2'h2

`endif

/* File: common/dcg_pkg.sv */
// Purpose: shared types of the deviation clear and gear block
// Assumes: nothing
// Notes:   numbers live in dcg_consts.svh
package dcg_pkg;
	// =================================================================
	// types
	typedef logic [31:0] dcg_word_t;
	typedef logic [15:0] dcg_half_t;
	typedef enum logic [1:0] {
		DCG_IDLE   = 2'b01,
		DCG_DIVIDE = 2'b10
	} dcg_core_e;
endpackage

/* File: common/dcg_gear_if.sv */
// Purpose: carries ratio and divide traffic between the gear modules
// Assumes: one clock domain
// Notes:   divisor is the denominator latched when start is seen
`timescale 1ns/100ps
`default_nettype none
interface dcg_gear_if;
	// =================================================================
	// ratio and divider signals
	logic [31:0] num;
	logic [31:0] den;
	logic        start;
	logic [31:0] dividend;
	logic        done;
	logic [31:0] quotient;
	logic [31:0] remainder;

	modport ratio  (output num, den);
	modport divsrv (input start, dividend, den,
		output done, quotient, remainder);
	modport core   (input num, den, done, quotient, remainder,
		output start, dividend);
endinterface
`default_nettype wire

/* File: logic/dcg_ratio.sv */
// Purpose: picks and forms the gear numerator and denominator
// Assumes: parameter values steady while pulses run
// Notes:   a zero denominator is forced to one
`timescale 1ns/100ps
`default_nettype none
`include "dcg_consts.svh"
module dcg_ratio (
	input  wire logic         clk,
	input  wire logic         arst_n,
	input  wire logic         clk_en,
	input  wire logic         width_long,
	input  wire dcg_pkg::dcg_half_t short_num,
	input  wire dcg_pkg::dcg_half_t short_den,
	input  wire dcg_pkg::dcg_half_t lnum_hi,
	input  wire dcg_pkg::dcg_half_t lnum_lo,
	input  wire dcg_pkg::dcg_half_t lden_hi,
	input  wire dcg_pkg::dcg_half_t lden_lo,
	dcg_gear_if.ratio         g
);
	import dcg_pkg::*;

	dcg_word_t num_d, num_q, den_d, den_q, lnum, lden;

	// =================================================================
	// ratio selection; registered to keep the multiply off the core path
	always_comb begin
		lnum = 32'(lnum_hi) * `DCG_LONG_SCALE + 32'(lnum_lo);
		lden = 32'(lden_hi) * `DCG_LONG_SCALE + 32'(lden_lo);
		num_d = width_long ? lnum : {16'h0000, short_num};
		den_d = width_long ? lden : {16'h0000, short_den};
		if (den_d == 32'h00000000) begin
			den_d = 32'h00000001;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			num_q <= 32'h00000001;
			den_q <= 32'h00000001;
		end else if (clk_en) begin
			num_q <= num_d;
			den_q <= den_d;
		end
	end

	assign g.num = num_q;
	assign g.den = den_q;
endmodule // dcg_ratio
`default_nettype wire

/* File: logic/dcg_divider.sv */
// Purpose: restoring divider, one quotient bit per enabled cycle
// Assumes: divisor non-zero
// Notes:   a new start abandons any division in flight
`timescale 1ns/100ps
`default_nettype none
`include "dcg_consts.svh"
module dcg_divider (
	input  wire logic clk,
	input  wire logic arst_n,
	input  wire logic clk_en,
	dcg_gear_if.divsrv g
);
	import dcg_pkg::*;

	dcg_word_t   acc_d, acc_q, quo_d, quo_q, dvs_d, dvs_q;
	logic [5:0]  cnt_d, cnt_q;
	logic        busy_d, busy_q, done_d, done_q;
	logic [32:0] trial;

	// =================================================================
	// shift dividend out of quo_q while quotient bits shift in
	always_comb begin
		acc_d  = acc_q;
		quo_d  = quo_q;
		dvs_d  = dvs_q;
		cnt_d  = cnt_q;
		busy_d = busy_q;
		done_d = 1'b0;
		trial  = {acc_q, quo_q[31]} - {1'b0, dvs_q};
		if (g.start) begin
			acc_d  = 32'h00000000;
			quo_d  = g.dividend;
			dvs_d  = g.den;
			cnt_d  = `DCG_DIV_STEPS;
			busy_d = 1'b1;
		end else if (busy_q) begin
			if (!trial[32]) begin
				acc_d = trial[31:0];
				quo_d = {quo_q[30:0], 1'b1};
			end else begin
				acc_d = {acc_q[30:0], quo_q[31]};
				quo_d = {quo_q[30:0], 1'b0};
			end
			cnt_d = cnt_q - 6'h01;
			if (cnt_q == 6'h01) begin
				busy_d = 1'b0;
				done_d = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			acc_q  <= 32'h00000000;
			quo_q  <= 32'h00000000;
			dvs_q  <= 32'h00000001;
			cnt_q  <= 6'h00;
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end else if (clk_en) begin
			acc_q  <= acc_d;
			quo_q  <= quo_d;
			dvs_q  <= dvs_d;
			cnt_q  <= cnt_d;
			busy_q <= busy_d;
			done_q <= done_d;
		end
	end

	assign g.done      = done_q;
	assign g.quotient  = quo_q;
	assign g.remainder = acc_q;
endmodule // dcg_divider
`default_nettype wire

/* File: logic/dcg_top.sv */
// Purpose: deviation counter with clear modes and electronic gear
// Assumes: inputs synchronous to clk; one reference pulse is a
//          one-cycle high on ref_pulse with ref_dir beside it
// Notes:   registers over AXI4-Lite; all state frozen while clk_en low
`timescale 1ns/100ps
`default_nettype none
`include "dcg_consts.svh"

// Functional notes
// - A low deviation clear input holds the deviation counter at zero.
// - A low deviation clear input stops the loop error output.
// - Pulses taken while servo is off stay unless a clear mode acts.
// - Mode 0 clears on servo off and keeps the count on overtravel.
// - Mode 1 never clears the counter on its own.
// - Mode 2 clears on servo off or overtravel unless zero clamp is on.
// - A width bit picks the short or the long ratio pair.
// - Long numerator and denominator are high times 10000 plus low.
// - Each reference pulse is one unit scaled by the chosen ratio.
module dcg_top (
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        clk_en,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        deviation_clear_n,
	input  wire logic        servo_on,
	input  wire logic        overtravel,
	input  wire logic        zero_clamp,
	input  wire logic        ref_pulse,
	input  wire logic        ref_dir,
	input  wire logic [15:0] fb_delta,
	output logic [31:0]      deviation,
	output logic [31:0]      loop_error,
	output logic             loop_run
);
	import dcg_pkg::*;

	// =================================================================
	// declarations
	dcg_half_t   clr_mode_d, clr_mode_q, gwidth_d, gwidth_q;
	dcg_half_t   snum_d, snum_q, sden_d, sden_q;
	dcg_half_t   lnh_d, lnh_q, lnl_d, lnl_q, ldh_d, ldh_q, ldl_d, ldl_q;
	logic [7:0]  awaddr_d, awaddr_q;
	dcg_word_t   wdata_d, wdata_q;
	logic [3:0]  wstrb_d, wstrb_q;
	logic        awh_d, awh_q, wh_d, wh_q;
	logic        awrdy_d, awrdy_q, wrdy_d, wrdy_q;
	logic        bvalid_d, bvalid_q, arrdy_d, arrdy_q;
	logic        rvalid_d, rvalid_q;
	logic [1:0]  bresp_d, bresp_q, rresp_d, rresp_q;
	dcg_word_t   rdata_d, rdata_q;
	dcg_core_e   state_d, state_q;
	logic signed [15:0] pend_d, pend_q;
	logic signed [31:0] dev_d, dev_q, err_d, err_q;
	dcg_word_t   rem_d, rem_q, divd_d, divd_q;
	logic        fwd_d, fwd_q, start_d, start_q;
	logic        run_d, run_q, clr_d, clr_q;
	logic [3:0]  mode;
	logic        auto_clr, clearing;
	logic signed [15:0] pend_in;

	dcg_gear_if  gif ();

	// =================================================================
	// gear helpers
	dcg_ratio u_ratio (
		.clk        (clk),
		.arst_n     (arst_n),
		.clk_en     (clk_en),
		.width_long (gwidth_q[`DCG_GEAR_LONG_BIT]),
		.short_num  (snum_q),
		.short_den  (sden_q),
		.lnum_hi    (lnh_q),
		.lnum_lo    (lnl_q),
		.lden_hi    (ldh_q),
		.lden_lo    (ldl_q),
		.g          (gif.ratio)
	);

	dcg_divider u_div (
		.clk    (clk),
		.arst_n (arst_n),
		.clk_en (clk_en),
		.g      (gif.divsrv)
	);

	assign gif.start    = start_q;
	assign gif.dividend = divd_q;

	// byte-lane merge into a 16-bit parameter
	function automatic dcg_half_t merge16(input dcg_half_t old,
		input dcg_word_t d, input logic [3:0] s);
		merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	// =================================================================
	// bus slave: address and data may arrive in either order
	always_comb begin
		awaddr_d   = awaddr_q;
		wdata_d    = wdata_q;
		wstrb_d    = wstrb_q;
		awh_d      = awh_q;
		wh_d       = wh_q;
		bvalid_d   = bvalid_q;
		bresp_d    = bresp_q;
		arrdy_d    = arrdy_q;
		rvalid_d   = rvalid_q;
		rresp_d    = rresp_q;
		rdata_d    = rdata_q;
		clr_mode_d = clr_mode_q;
		gwidth_d   = gwidth_q;
		snum_d     = snum_q;
		sden_d     = sden_q;
		lnh_d      = lnh_q;
		lnl_d      = lnl_q;
		ldh_d      = ldh_q;
		ldl_d      = ldl_q;
		if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
		if (s_axi_awvalid && awrdy_q) begin
			awh_d    = 1'b1;
			awaddr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && wrdy_q) begin
			wh_d    = 1'b1;
			wdata_d = s_axi_wdata;
			wstrb_d = s_axi_wstrb;
		end
		// write only once the previous response has gone
		if (awh_q && wh_q && !bvalid_q) begin
			awh_d    = 1'b0;
			wh_d     = 1'b0;
			bvalid_d = 1'b1;
			bresp_d  = `DCG_RESP_OKAY;
			case (awaddr_q)
				`DCG_OFF_CLR_MODE:
					clr_mode_d = merge16(clr_mode_q, wdata_q, wstrb_q);
				`DCG_OFF_GEAR_WIDTH:
					gwidth_d = merge16(gwidth_q, wdata_q, wstrb_q);
				`DCG_OFF_SHORT_NUM: snum_d = merge16(snum_q, wdata_q, wstrb_q);
				`DCG_OFF_SHORT_DEN: sden_d = merge16(sden_q, wdata_q, wstrb_q);
				`DCG_OFF_LNUM_HI:   lnh_d  = merge16(lnh_q, wdata_q, wstrb_q);
				`DCG_OFF_LNUM_LO:   lnl_d  = merge16(lnl_q, wdata_q, wstrb_q);
				`DCG_OFF_LDEN_HI:   ldh_d  = merge16(ldh_q, wdata_q, wstrb_q);
				`DCG_OFF_LDEN_LO:   ldl_d  = merge16(ldl_q, wdata_q, wstrb_q);
				`DCG_OFF_DEVIATION, `DCG_OFF_STATUS: bresp_d = `DCG_RESP_OKAY;
				default: bresp_d = `DCG_RESP_SLVERR;
			endcase
		end
		awrdy_d = !awh_d;
		wrdy_d  = !wh_d;
		// reads answer one cycle after the address is taken
		if (rvalid_q && s_axi_rready) begin
			rvalid_d = 1'b0;
			arrdy_d  = 1'b1;
		end
		if (s_axi_arvalid && arrdy_q) begin
			arrdy_d  = 1'b0;
			rvalid_d = 1'b1;
			rresp_d  = `DCG_RESP_OKAY;
			case (s_axi_araddr)
				`DCG_OFF_CLR_MODE:   rdata_d = {16'h0000, clr_mode_q};
				`DCG_OFF_GEAR_WIDTH: rdata_d = {16'h0000, gwidth_q};
				`DCG_OFF_SHORT_NUM:  rdata_d = {16'h0000, snum_q};
				`DCG_OFF_SHORT_DEN:  rdata_d = {16'h0000, sden_q};
				`DCG_OFF_LNUM_HI:    rdata_d = {16'h0000, lnh_q};
				`DCG_OFF_LNUM_LO:    rdata_d = {16'h0000, lnl_q};
				`DCG_OFF_LDEN_HI:    rdata_d = {16'h0000, ldh_q};
				`DCG_OFF_LDEN_LO:    rdata_d = {16'h0000, ldl_q};
				`DCG_OFF_DEVIATION:  rdata_d = dev_q;
				`DCG_OFF_STATUS: rdata_d = {29'h00000000,
					state_q == DCG_DIVIDE, clr_q, run_q};
				default: begin
					rdata_d = 32'h00000000;
					rresp_d = `DCG_RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			awaddr_q   <= 8'h00;
			wdata_q    <= 32'h00000000;
			wstrb_q    <= 4'h0;
			awh_q      <= 1'b0;
			wh_q       <= 1'b0;
			awrdy_q    <= 1'b1;
			wrdy_q     <= 1'b1;
			bvalid_q   <= 1'b0;
			bresp_q    <= `DCG_RESP_OKAY;
			arrdy_q    <= 1'b1;
			rvalid_q   <= 1'b0;
			rresp_q    <= `DCG_RESP_OKAY;
			rdata_q    <= 32'h00000000;
			clr_mode_q <= `DCG_RST_CLR_MODE;
			gwidth_q   <= `DCG_RST_GEAR_WIDTH;
			snum_q     <= `DCG_RST_SHORT_NUM;
			sden_q     <= `DCG_RST_SHORT_DEN;
			lnh_q      <= `DCG_RST_LONG_HI;
			lnl_q      <= `DCG_RST_LONG_LO;
			ldh_q      <= `DCG_RST_LONG_HI;
			ldl_q      <= `DCG_RST_LONG_LO;
		end else if (clk_en) begin
			awaddr_q   <= awaddr_d;
			wdata_q    <= wdata_d;
			wstrb_q    <= wstrb_d;
			awh_q      <= awh_d;
			wh_q       <= wh_d;
			awrdy_q    <= awrdy_d;
			wrdy_q     <= wrdy_d;
			bvalid_q   <= bvalid_d;
			bresp_q    <= bresp_d;
			arrdy_q    <= arrdy_d;
			rvalid_q   <= rvalid_d;
			rresp_q    <= rresp_d;
			rdata_q    <= rdata_d;
			clr_mode_q <= clr_mode_d;
			gwidth_q   <= gwidth_d;
			snum_q     <= snum_d;
			sden_q     <= sden_d;
			lnh_q      <= lnh_d;
			lnl_q      <= lnl_d;
			ldh_q      <= ldh_d;
			ldl_q      <= ldl_d;
		end
	end

	// =================================================================
	// clear decision
	always_comb begin
		mode = clr_mode_q[`DCG_CLR_MODE_MSB:`DCG_CLR_MODE_LSB];
		case (mode)
			`DCG_MODE_SERVO_OFF: auto_clr = !servo_on;
			`DCG_MODE_NEVER: auto_clr = 1'b0;
			// off or overtravel, not in clamp
			`DCG_MODE_BOTH: auto_clr = !zero_clamp && (!servo_on || overtravel);
			default: auto_clr = 1'b0; // reserved codes behave as never
		endcase
		clearing = !deviation_clear_n || auto_clr;
	end

	// =================================================================
	// gear engine and deviation counter
	// pulses queue in pend_q because a division takes 34 cycles
	always_comb begin
		state_d = state_q;
		fwd_d   = fwd_q;
		rem_d   = rem_q;
		divd_d  = divd_q;
		start_d = 1'b0;
		pend_in = ref_pulse ? (ref_dir ? 16'sh0001 : -16'sh0001) : 16'sh0000;
		pend_d  = pend_q + pend_in;
		dev_d   = dev_q - 32'(signed'(fb_delta));
		case (state_q)
			DCG_IDLE: begin
				if (pend_q != 16'sh0000) begin
					fwd_d   = !pend_q[15];
					pend_d  = pend_q + pend_in + (pend_q[15] ? 16'sh0001 : -16'sh0001);
					divd_d  = pend_q[15] ? gif.num + gif.den - 32'h00000001 - rem_q
						: rem_q + gif.num;
					start_d = 1'b1;
					state_d = DCG_DIVIDE;
				end
			end
			DCG_DIVIDE: begin
				if (gif.done) begin
					dev_d   = fwd_q ? dev_d + signed'(gif.quotient)
						: dev_d - signed'(gif.quotient);
					rem_d   = fwd_q ? gif.remainder
						: gif.den - 32'h00000001 - gif.remainder;
					state_d = DCG_IDLE;
				end
			end
			default: state_d = DCG_IDLE;
		endcase
		// clear forces zero, pending pulses dropped too
		if (clearing) begin
			dev_d   = 32'sh00000000;
			pend_d  = 16'sh0000;
			rem_d   = 32'h00000000;
			start_d = 1'b0;
			state_d = DCG_IDLE;
		end
		run_d = deviation_clear_n;
		err_d = run_d ? dev_d : 32'sh00000000;
		clr_d = clearing;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= DCG_IDLE;
			fwd_q   <= 1'b1;
			rem_q   <= 32'h00000000;
			divd_q  <= 32'h00000000;
			start_q <= 1'b0;
			pend_q  <= 16'sh0000;
			dev_q   <= 32'sh00000000;
			err_q   <= 32'sh00000000;
			run_q   <= 1'b0;
			clr_q   <= 1'b0;
		end else if (clk_en) begin
			state_q <= state_d;
			fwd_q   <= fwd_d;
			rem_q   <= rem_d;
			divd_q  <= divd_d;
			start_q <= start_d;
			pend_q  <= pend_d;
			dev_q   <= dev_d;
			err_q   <= err_d;
			run_q   <= run_d;
			clr_q   <= clr_d;
		end
	end

	// =================================================================
	// outputs, all straight from flops
	assign s_axi_awready = awrdy_q;
	assign s_axi_wready  = wrdy_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = arrdy_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rresp   = rresp_q;
	assign s_axi_rdata   = rdata_q;
	assign deviation     = dev_q;
	assign loop_error    = err_q;
	assign loop_run      = run_q;
endmodule // dcg_top
`default_nettype wire

/* File: test/dcg_top_chk.sv */
// Purpose: port-level checks for dcg_top
// Assumes: clk_en high while the counter is judged
// Notes:   the feedback check waits until the gear has gone quiet
`timescale 1ns/100ps
`default_nettype none
module dcg_top_chk (
	input wire logic        clk,
	input wire logic        arst_n,
	input wire logic        clk_en,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        deviation_clear_n,
	input wire logic        servo_on,
	input wire logic        overtravel,
	input wire logic        ref_pulse,
	input wire logic [15:0] fb_delta,
	input wire logic [31:0] deviation,
	input wire logic [31:0] loop_error,
	input wire logic        loop_run
);
	// =========================================================
	// quiet time since the last pulse; two queued pulses settle
	// well inside 100 cycles, so the gear adds nothing after it
	logic [7:0]  quiet_q;
	logic        quiet;
	logic [31:0] fb_ext;
	assign quiet  = (quiet_q == 8'h64);
	assign fb_ext = {{16{fb_delta[15]}}, fb_delta};

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			quiet_q <= 8'h00;
		else if (clk_en && ref_pulse)
			quiet_q <= 8'h00;
		else if (clk_en && !quiet)
			quiet_q <= quiet_q + 8'h01;
	end

	default clocking dc @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	// =========================================================
	// counter, loop and bus relations
	chk_clear_zero: assert property (
		clk_en && !deviation_clear_n |=> deviation == 32'h0)
		else $error("deviation not zero under clear pin");
	chk_run_follow: assert property (
		clk_en && $past(arst_n)
		|=> loop_run == $past(deviation_clear_n))
		else $error("loop_run does not follow clear pin");
	chk_error_gate: assert property (
		loop_error == (loop_run ? deviation : 32'h0))
		else $error("loop_error not gated by loop_run");
	chk_fb_sub: assert property (
		clk_en && deviation_clear_n && servo_on && !overtravel && quiet
		|=> deviation == $past(deviation) - $past(fb_ext))
		else $error("feedback not subtracted");
	chk_wr_answer: assert property (
		clk_en && s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |=> ##1 s_axi_bvalid)
		else $error("write response late");
	chk_wr_busy: assert property (
		clk_en && s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |=> !s_axi_awready && !s_axi_wready)
		else $error("write slot not closed");
	chk_rd_answer: assert property (
		clk_en && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	chk_rd_busy: assert property (
		s_axi_rvalid |-> !s_axi_arready)
		else $error("second read accepted");
endmodule // dcg_top_chk

bind dcg_top dcg_top_chk chk_u (
	.clk(clk), .arst_n(arst_n), .clk_en(clk_en),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.deviation_clear_n(deviation_clear_n), .servo_on(servo_on),
	.overtravel(overtravel), .ref_pulse(ref_pulse),
	.fb_delta(fb_delta), .deviation(deviation),
	.loop_error(loop_error), .loop_run(loop_run)
);
`default_nettype wire

/* File: test/dcg_host_model.sv */
// Purpose: host controller giving reference pulses and the clear pin
// Assumes: tasks are called right after a rising edge
// Notes:   direction is scrambled between pulses
`timescale 1ns/100ps
`default_nettype none
module dcg_host_model (
	input  wire logic clk,
	output var logic  ref_pulse,
	output var logic  ref_dir,
	output var logic  deviation_clear_n
);
	// =========================================================
	// one pulse then gap cycles; direction flips outside the
	// pulse so a block that samples it late is caught
	initial begin
		ref_pulse         <= 1'b0;
		ref_dir           <= 1'b0;
		deviation_clear_n <= 1'b1;
	end

	task automatic send(input logic dir, input int gap);
		@(posedge clk);
		ref_pulse <= 1'b1;
		ref_dir   <= dir;
		@(posedge clk);
		ref_pulse <= 1'b0;
		ref_dir   <= ~dir;
		repeat (gap) @(posedge clk);
	endtask

	task automatic set_clear(input logic lvl);
		@(posedge clk);
		deviation_clear_n <= lvl;
	endtask
endmodule // dcg_host_model
`default_nettype wire

/* File: test/dcg_top_tb.sv */
// Purpose: self-checking bench for dcg_top
// Assumes: byte strobes held high
// Notes:   gear results are read 40 cycles after each single pulse, 80 after a queued pair
`timescale 1ns/100ps
`default_nettype none
`include "dcg_consts.svh"
module dcg_top_tb;
	logic        clk, arst_n, clk_en, awvalid, awready, wvalid, wready;
	logic        bvalid, bready, arvalid, arready, rvalid, rready;
	logic        servo_on, overtravel, zero_clamp, clr_n, ref_pulse;
	logic        ref_dir, loop_run;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, deviation, loop_error;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic [15:0] fb_delta;
	int          fails, n_tests, cyc;

	// =========================================================
	// design and host controller
	dcg_top dut_u (
		.clk(clk), .arst_n(arst_n), .clk_en(clk_en),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.deviation_clear_n(clr_n), .servo_on(servo_on),
		.overtravel(overtravel), .zero_clamp(zero_clamp),
		.ref_pulse(ref_pulse), .ref_dir(ref_dir), .fb_delta(fb_delta),
		.deviation(deviation), .loop_error(loop_error), .loop_run(loop_run)
	);
	dcg_host_model host_u (.clk(clk), .ref_pulse(ref_pulse),
		.ref_dir(ref_dir), .deviation_clear_n(clr_n));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// cuts a hang short; the tests need about a thousand cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			end_of_test();
		end
	end

	// =========================================================
	// comparison and bus tasks; outputs read right after an edge
	// still hold what the design sampled there
	task automatic chk(input string what, input logic [31:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge clk);
	endtask

	// registers lie one word apart from the clear mode register
	task automatic cfg(input logic [15:0] m, w, sn, sd, nh, nl, dh, dl);
		logic [15:0] v [8];
		logic [1:0]  r;
		v = '{m, w, sn, sd, nh, nl, dh, dl};
		foreach (v[i]) wr(`DCG_OFF_CLR_MODE + 8'(4 * i), {16'h0, v[i]}, r);
	endtask

	// one cycle of negative feedback raises the counter
	task automatic load(input logic [15:0] n);
		fb_delta <= n;
		@(posedge clk);
		fb_delta <= 16'h0000;
		repeat (2) @(posedge clk);
	endtask

	task automatic zero;
		host_u.set_clear(1'b0);
		host_u.set_clear(1'b1);
		repeat (2) @(posedge clk);
	endtask

	// =========================================================
	// scenarios
	task automatic t_regs;
		logic [15:0] rv [8];
		logic [31:0] d;
		logic [1:0]  r;
		rv = '{16'h0, 16'h0, 16'h1, 16'h1, 16'h0, 16'h1, 16'h0, 16'h1};
		foreach (rv[i]) begin
			rd(8'(4 * i), d, r);
			chk("reset value", d, {16'h0, rv[i]});
			wr(8'(4 * i), 32'hFFFF_5A50 | 32'(i), r);
			rd(8'(4 * i), d, r);
			chk("read back", d, 32'h0000_5A50 | 32'(i));
		end
		rd(8'h40, d, r);
		chk("unmapped resp", {30'h0, r}, {30'h0, `DCG_RESP_SLVERR});
		chk("unmapped data", d, 32'h0);
		wr(8'h40, 32'h0, r);
		chk("unmapped write", {30'h0, r}, {30'h0, `DCG_RESP_SLVERR});
		wr(`DCG_OFF_DEVIATION, 32'h1234, r);
		rd(`DCG_OFF_DEVIATION, d, r);
		chk("read only kept", d, 32'h0);
		$display("test registers done");
	endtask

	task automatic t_short;
		int k;
		zero();
		cfg(16'h0, 16'h0, 16'h3, 16'h2, 16'h0, 16'h7, 16'h0, 16'h1);
		for (k = 1; k <= 4; k++) begin
			host_u.send(1'b1, 40);
			chk("forward counts", deviation, 32'(k * 3 / 2));
		end
		for (k = 3; k >= 0; k--) begin
			host_u.send(1'b0, 40);
			chk("reverse counts", deviation, 32'(k * 3 / 2));
		end
		host_u.send(1'b1, 0);
		host_u.send(1'b1, 80);
		chk("queued pair", deviation, 32'h3);
		$display("test short gear done");
	endtask

	task automatic t_long;
		int k;
		zero();
		cfg(16'h0, 16'h4, 16'h7, 16'h1, 16'h2, 16'h1388, 16'h1, 16'h0);
		for (k = 1; k <= 2; k++) begin
			host_u.send(1'b1, 40);
			chk("long gear", deviation, 32'(k * 5 / 2));
		end
		clk_en <= 1'b0;
		load(16'hFFFF);
		chk("frozen", deviation, 32'h5);
		clk_en <= 1'b1;
		$display("test long gear done");
	endtask

	task automatic t_pin;
		logic [31:0] d;
		logic [1:0]  r;
		chk("error follows", loop_error, 32'h5);
		host_u.set_clear(1'b0);
		load(16'hFFFD);
		host_u.send(1'b1, 40);
		chk("pin clear", deviation, 32'h0);
		chk("loop stopped", loop_error, 32'h0);
		chk("run low", 32'(loop_run), 32'h0);
		rd(`DCG_OFF_STATUS, d, r);
		chk("status clearing", d, 32'h2);
		host_u.set_clear(1'b1);
		repeat (3) @(posedge clk);
		chk("run high", 32'(loop_run), 32'h1);
		$display("test clear pin done");
	endtask

	task automatic t_auto;
		logic [31:0] e;
		for (int m = 0; m < 3; m++) begin
			cfg(16'(m * 16), 16'h0, 16'h1, 16'h1, 16'h0, 16'h1, 16'h0, 16'h1);
			load(16'hFFF7);
			servo_on <= 1'b0;
			repeat (3) @(posedge clk);
			e = (m == 1) ? 32'h9 : 32'h0;
			chk("servo off", deviation, e);
			host_u.send(1'b1, 40);
			chk("pulse at off", deviation, (m == 1) ? 32'hA : 32'h0);
			servo_on <= 1'b1;
			load(16'hFFFC);
			e = (m == 1) ? 32'hE : 32'h4;
			overtravel <= 1'b1;
			zero_clamp <= 1'b1;
			repeat (3) @(posedge clk);
			chk("clamp keeps", deviation, e);
			zero_clamp <= 1'b0;
			repeat (3) @(posedge clk);
			chk("overtravel", deviation, (m == 2) ? 32'h0 : e);
			overtravel <= 1'b0;
			zero();
		end
		$display("test auto clear done");
	endtask

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// =========================================================
	// reset for 16 cycles, then the scenarios
	initial begin
		arst_n     = 1'b0;
		clk_en     = 1'b1;
		wstrb      = 4'hF;
		awaddr     = 8'h00;
		awvalid    = 1'b0;
		wdata      = 32'h0;
		wvalid     = 1'b0;
		bready     = 1'b0;
		araddr     = 8'h00;
		arvalid    = 1'b0;
		rready     = 1'b0;
		servo_on   = 1'b1;
		overtravel = 1'b0;
		zero_clamp = 1'b0;
		fb_delta   = 16'h0000;
		repeat (16) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		t_regs();
		t_short();
		t_long();
		t_pin();
		t_auto();
		end_of_test();
	end
endmodule // dcg_top_tb
`default_nettype wire
